// ### verilog/rtc_ctrl_regs.sv
// control and status registers of the calendar clock core, reached through an index/data port
//
// What this block does
// RULE_01 - b bit7 set halts time counter updates
// RULE_02 - b bit6 enables periodic interrupt at rate
// RULE_03 - alarm sets c bit5, irq if b5
// RULE_04 - update end sets c bit4, irq if b4
// RULE_05 - each periodic interval sets c bit6
// RULE_06 - c bit7 mirrors interrupt output, read only
// RULE_07 - b bit2 picks bcd or binary format
// RULE_08 - b bit1 picks 12 or 24 hour
// RULE_09 - b bit0 enables daylight saving hour shifts
// RULE_10 - d bit7 shows supply kept, zero if lost
// RULE_11 - a bit7 warns update within 2444 us
// RULE_12 - divider runs only with pattern 010
// RULE_13 - rate 0000 none, 0011 122us, doubling upward
// RULE_14 - interrupt when any flag meets its enable
// RULE_15 - reading c clears flags, drops interrupt
`timescale 1ns/1ps
`include "rtc_ctrl_cfg.svh"

module rtc_ctrl_regs
  import rtc_ctrl_pkg::*;
#(
  parameter int TB_DIV = `CLK_HZ / `TB_HZ,
  parameter int UIP_CYCLES = (`CLK_HZ / 1000000) * `UIP_WINDOW_US
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // index/data port
  input wire logic I_IDX_WR,
  input wire logic I_DATA_WR,
  input wire logic I_DATA_RD,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  // link to the time counters and alarm comparators
  input wire logic I_ALARM_MATCH,
  input wire logic I_POWER_GOOD,
  output logic O_SECOND_TICK,
  output logic O_UPDATE_HALT,
  output logic O_BINARY,
  output logic O_HOUR24,
  output logic O_DST_EN,
  // interrupt request
  output logic O_IRQ
);

  // the warning window must close before the second boundary it announces
  if (TB_DIV < 2 || UIP_CYCLES < 1 || UIP_CYCLES >= `UIP_LEAD_TICKS * TB_DIV) begin : g_bad_params
    $error("rtc_ctrl_regs: bad divider parameters");
  end

  localparam int TB_W = $clog2(TB_DIV);
  localparam int UIP_W = $clog2(UIP_CYCLES + 1);

  logic [6:0] index_ff;
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic pf_ff, af_ff, uf_ff;
  logic power_ok_ff;
  logic [TB_W-1:0] tb_cnt_ff;
  logic tb_tick;
  logic [14:0] div_ff;
  logic [14:0] nxt_div;
  logic sec_edge, per_edge;
  logic [3:0] rate;
  logic [UIP_W-1:0] uip_cnt_ff;
  upd_state_type state_ff;
  logic upd_done;
  logic irq_now;
  logic rd_c;

  ////////////////////////////////////////////////////////////////////////
  // index latch and register writes
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      index_ff <= 7'h00;
    end else if (I_IDX_WR) begin
      index_ff <= I_WDATA[6:0]; // bit 7 of the index byte belongs to the nmi mask, not here
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_a_ff <= `RST_CTRL_A;
      ctrl_b_ff <= `RST_CTRL_B;
    end else if (I_DATA_WR) begin
      if (index_ff == `OFF_CTRL_A) begin
        ctrl_a_ff[6:0] <= I_WDATA[6:0]; // update flag stays hardware owned
      end
      if (index_ff == `OFF_CTRL_B) begin
        ctrl_b_ff <= {I_WDATA[7:4], 1'b0, I_WDATA[2:0]}; // reserved bit kept at zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 32.768 khz time base and divider chain
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tb_cnt_ff <= '0;
    end else if (tb_tick) begin
      tb_cnt_ff <= '0;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + 1'b1;
    end
  end
  assign tb_tick = (tb_cnt_ff == TB_W'(TB_DIV - 1));

  // only the normal pattern runs the chain; other codes hold it in reset
  always_ff @(posedge I_CLK) begin
    if (I_SRST || ctrl_a_ff[6:4] != `DIV_NORMAL) begin // RULE_12
      div_ff <= 15'h0000;
    end else if (tb_tick) begin
      div_ff <= nxt_div;
    end
  end
  assign nxt_div = div_ff + 15'h0001;
  assign sec_edge = tb_tick && (div_ff == 15'h7fff) && (ctrl_a_ff[6:4] == `DIV_NORMAL);

  // codes 1 and 2 alias codes 8 and 9; tap n toggles at 2^(n-1) time base ticks
  assign rate = ctrl_a_ff[3:0];
  always_comb begin
    logic [3:0] tap;
    tap = (rate == 4'h1) ? 4'h8 : (rate == 4'h2) ? 4'h9 : rate;
    per_edge = 1'b0;
    if (rate != 4'h0 && tb_tick && ctrl_a_ff[6:4] == `DIV_NORMAL) begin // RULE_13
      per_edge = (nxt_div & ((15'h0001 << (tap - 4'h1)) - 15'h0001)) == 15'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // update cycle sequencer: warning window, then one update
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_ff <= ST_IDLE;
      uip_cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // warning opens a fixed window before the second boundary
          if (!ctrl_b_ff[`B_INHIBIT] && ctrl_a_ff[6:4] == `DIV_NORMAL &&
              div_ff == 15'h7fff - 15'(`UIP_LEAD_TICKS - 1) && tb_tick) begin // RULE_11
            state_ff <= ST_WARN;
            uip_cnt_ff <= UIP_W'(UIP_CYCLES);
          end
        end
        ST_WARN: begin
          if (uip_cnt_ff == '0) begin
            state_ff <= ST_UPDATE;
          end else begin
            uip_cnt_ff <= uip_cnt_ff - 1'b1;
          end
        end
        ST_UPDATE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign upd_done = (state_ff == ST_UPDATE) && !ctrl_b_ff[`B_INHIBIT];

  ////////////////////////////////////////////////////////////////////////
  // status flags; an event in the clearing read cycle wins
  assign rd_c = I_DATA_RD && index_ff == `OFF_FLAGS_C;
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pf_ff <= 1'b0;
      af_ff <= 1'b0;
      uf_ff <= 1'b0;
    end else begin
      pf_ff <= per_edge | (pf_ff & ~rd_c); // RULE_05 RULE_15
      af_ff <= I_ALARM_MATCH | (af_ff & ~rd_c); // RULE_03
      uf_ff <= upd_done | (uf_ff & ~rd_c); // RULE_04
    end
  end

  // power status latches low on supply loss until register d is read back
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      power_ok_ff <= 1'b0;
    end else if (!I_POWER_GOOD) begin
      power_ok_ff <= 1'b0;
    end else if (I_DATA_RD && index_ff == `OFF_POWER_D) begin
      power_ok_ff <= 1'b1; // RULE_10
    end
  end

  assign irq_now = (pf_ff & ctrl_b_ff[`B_PIE]) | (af_ff & ctrl_b_ff[`B_AIE]) | // RULE_02 RULE_14
                   (uf_ff & ctrl_b_ff[`B_UIE]);

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_IRQ <= 1'b0;
      O_SECOND_TICK <= 1'b0;
      O_UPDATE_HALT <= 1'b0;
      O_BINARY <= 1'b0;
      O_HOUR24 <= 1'b0;
      O_DST_EN <= 1'b0;
    end else begin
      O_IRQ <= irq_now & ~rd_c; // RULE_15
      O_SECOND_TICK <= sec_edge & ~ctrl_b_ff[`B_INHIBIT]; // RULE_01
      O_UPDATE_HALT <= ctrl_b_ff[`B_INHIBIT]; // RULE_01
      O_BINARY <= ctrl_b_ff[`B_BINARY]; // RULE_07
      O_HOUR24 <= ctrl_b_ff[`B_H24]; // RULE_08
      O_DST_EN <= ctrl_b_ff[`B_DST]; // RULE_09
    end
  end

  // read data is registered: visible the cycle after the read strobe
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_RDATA <= 8'h00;
    end else if (I_DATA_RD) begin
      case (index_ff)
        `OFF_CTRL_A: O_RDATA <= {state_ff != ST_IDLE, ctrl_a_ff[6:0]}; // RULE_11
        `OFF_CTRL_B: O_RDATA <= ctrl_b_ff;
        `OFF_FLAGS_C: O_RDATA <= {O_IRQ, pf_ff, af_ff, uf_ff, 4'h0}; // RULE_06
        `OFF_POWER_D: O_RDATA <= {power_ok_ff, 7'h00}; // RULE_10
        default: O_RDATA <= 8'h00;
      endcase
    end
  end

endmodule // rtc_ctrl_regs

// ### verilog/rtc_ctrl_cfg.svh
// offsets, field positions, reset values and timing counts of the clock control block
`ifndef RTC_CTRL_CFG_SVH
`define RTC_CTRL_CFG_SVH

// register indices on the index/data port
`define OFF_CTRL_A 7'h0a
`define OFF_CTRL_B 7'h0b
`define OFF_FLAGS_C 7'h0c
`define OFF_POWER_D 7'h0d

// control register b fields
`define B_INHIBIT 7
`define B_PIE 6
`define B_AIE 5
`define B_UIE 4
`define B_BINARY 2
`define B_H24 1
`define B_DST 0

// flag register c fields
`define C_IRQ 7
`define C_PF 6
`define C_AF 5
`define C_UF 4

// register a fields
`define A_UIP 7
`define DIV_NORMAL 3'h2

// reset values
`define RST_CTRL_A 8'h26
`define RST_CTRL_B 8'h02

// time base and update warning window
`define TB_HZ 32768
`define UIP_WINDOW_US 2444
`define UIP_LEAD_TICKS 82
`define CLK_HZ 40000000

`endif

// ### verilog/rtc_ctrl_pkg.sv
// types shared by the clock control block
package rtc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WARN,
    ST_UPDATE
  } upd_state_type;
endpackage

// ### tb/rtc_ctrl_regs_properties.sv
// concurrent checks on the clock control register ports
`timescale 1ns/1ps
module rtc_ctrl_regs_properties (
  // clock, reset and host side
  input wire logic I_CLK, I_SRST, I_IDX_WR, I_DATA_WR, I_DATA_RD, I_ALARM_MATCH, I_POWER_GOOD,
  input wire logic [7:0] I_WDATA,
  // watched outputs
  input wire logic [7:0] O_RDATA,
  input wire logic O_UPDATE_HALT, O_BINARY, O_HOUR24, O_DST_EN, O_IRQ
);
  logic [6:0] idx_ff;
  logic [7:0] b_ff;
  // shadow of index and control b; bit 3 is dropped since it always reads 0
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      idx_ff <= 7'h00;
      b_ff <= 8'h02;
    end else begin
      if (I_IDX_WR) idx_ff <= I_WDATA[6:0];
      if (I_DATA_WR && idx_ff == 7'h0b) b_ff <= I_WDATA & 8'hf7;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  property p_halt; !$past(I_SRST) |-> O_UPDATE_HALT == $past(b_ff[7]); endproperty
  property p_bin; !$past(I_SRST) |-> O_BINARY == $past(b_ff[2]); endproperty
  property p_h24; !$past(I_SRST) |-> O_HOUR24 == $past(b_ff[1]); endproperty
  property p_dst; !$past(I_SRST) |-> O_DST_EN == $past(b_ff[0]); endproperty
  property p_rdb; I_DATA_RD && idx_ff == 7'h0b |=> O_RDATA == $past(b_ff); endproperty
  property p_irqc; I_DATA_RD && idx_ff == 7'h0c |=> O_RDATA[7] == $past(O_IRQ); endproperty
  property p_alarm; I_ALARM_MATCH && b_ff[5] |-> ##[1:3] O_IRQ; endproperty
  property p_quiet; $past(b_ff[6:4]) == 3'h0 |-> !O_IRQ; endproperty
  property p_pwr; I_DATA_RD && idx_ff == 7'h0d && $past(!I_POWER_GOOD) |=> !O_RDATA[7]; endproperty
  a_halt: assert property (p_halt) else $error("halt level wrong");
  a_bin: assert property (p_bin) else $error("format level wrong");
  a_h24: assert property (p_h24) else $error("hour mode level wrong");
  a_dst: assert property (p_dst) else $error("dst level wrong");
  a_rdb: assert property (p_rdb) else $error("control b readback wrong");
  a_irqc: assert property (p_irqc) else $error("flag bit 7 not irq");
  a_alarm: assert property (p_alarm) else $error("alarm irq missing");
  a_quiet: assert property (p_quiet) else $error("irq with no enable");
  a_pwr: assert property (p_pwr) else $error("power bit set after loss");
  cover property (O_IRQ);
  cover property (I_ALARM_MATCH && !b_ff[5]);
  cover property (I_DATA_RD && idx_ff == 7'h0d);
endmodule // rtc_ctrl_regs_properties

// ### tb/rtc_ctrl_regs_tb.sv
// self-checking bench for the clock control register block
`timescale 1ns/1ps
module rtc_ctrl_regs_tb;
  logic I_CLK = 1'h0, I_SRST = 1'h1, I_IDX_WR = 1'h0, I_DATA_WR = 1'h0, I_DATA_RD = 1'h0;
  logic I_ALARM_MATCH = 1'h0, I_POWER_GOOD = 1'h1;
  logic [7:0] I_WDATA = 8'h00;
  logic [7:0] O_RDATA, q, b_m;
  logic O_SECOND_TICK, O_UPDATE_HALT, O_BINARY, O_HOUR24, O_DST_EN, O_IRQ;
  int fail_count = 0, comparisons = 0, cycles = 0, n;
  // shortest time base, so that one whole second fits inside the run
  rtc_ctrl_regs #(.TB_DIV(2), .UIP_CYCLES(20)) u_rtc_ctrl_regs (.I_CLK, .I_SRST, .I_IDX_WR, .I_DATA_WR,
    .I_DATA_RD, .I_WDATA, .O_RDATA, .I_ALARM_MATCH, .I_POWER_GOOD, .O_SECOND_TICK, .O_UPDATE_HALT,
    .O_BINARY, .O_HOUR24, .O_DST_EN, .O_IRQ);
  always #12.5 I_CLK = ~I_CLK;
  // hang guard; one simulated second takes about 66k cycles
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge I_CLK);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // index cycle then one data strobe; read data is taken a cycle later
  task automatic acc(input logic [6:0] a, input logic wr, input logic [7:0] d);
    I_IDX_WR = 1'h1;
    I_WDATA = {1'h0, a};
    cyc(1);
    I_IDX_WR = 1'h0;
    I_DATA_WR = wr;
    I_DATA_RD = !wr;
    I_WDATA = d;
    cyc(1);
    I_DATA_WR = 1'h0;
    I_DATA_RD = 1'h0;
    q = O_RDATA;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    acc(a, 1'h0, 8'h00);
    chk(q, e);
  endtask
  task automatic alarm();
    I_ALARM_MATCH = 1'h1;
    cyc(1);
    I_ALARM_MATCH = 1'h0;
    cyc(2);
  endtask
  initial begin
    void'($urandom(588));
    cyc(3);
    I_SRST = 1'h0;
    rdchk(7'h0b, 8'h02);
    rdchk(7'h0a, 8'h26);
    acc(7'h0d, 1'h0, 8'h00);
    rdchk(7'h0d, 8'h80);
    acc(7'h0a, 1'h1, 8'ha0);
    rdchk(7'h0a, 8'h20);
    for (int i = 0; i < 8; i++) begin
      b_m = 8'($urandom);
      acc(7'h0b, 1'h1, b_m);
      b_m[3] = 1'h0;
      cyc(1);
      chk({O_UPDATE_HALT, 4'h0, O_BINARY, O_HOUR24, O_DST_EN}, b_m & 8'h87);
      rdchk(7'h0b, b_m);
    end
    // writes to status and unmapped places are dropped
    acc(7'h0c, 1'h1, 8'hff);
    acc(7'h3f, 1'h1, 8'hff);
    rdchk(7'h3f, 8'h00);
    rdchk(7'h0c, 8'h00);
    acc(7'h0b, 1'h1, 8'h22);
    alarm();
    chk({7'h00, O_IRQ}, 8'h01);
    rdchk(7'h0c, 8'ha0);
    cyc(1);
    chk({7'h00, O_IRQ}, 8'h00);
    rdchk(7'h0c, 8'h00);
    acc(7'h0b, 1'h1, 8'h02);
    alarm();
    chk({7'h00, O_IRQ}, 8'h00);
    rdchk(7'h0c, 8'h20);
    acc(7'h0a, 1'h1, 8'h23);
    cyc(60);
    chk({7'h00, O_IRQ}, 8'h00);
    acc(7'h0b, 1'h1, 8'h42);
    n = 0;
    while (O_IRQ !== 1'h1 && n < 200) begin
      cyc(1);
      n++;
    end
    acc(7'h0a, 1'h1, 8'h20);
    acc(7'h0c, 1'h0, 8'h00);
    chk(q & 8'hc0, 8'hc0);
    I_POWER_GOOD = 1'h0;
    cyc(1);
    rdchk(7'h0d, 8'h00);
    I_POWER_GOOD = 1'h1;
    acc(7'h0d, 1'h0, 8'h00);
    rdchk(7'h0d, 8'h80);
    // rest of the first second: warning window, end of update, then the second tick
    acc(7'h0b, 1'h1, 8'h12);
    n = 0;
    q = 8'h00;
    while (q[7] !== 1'h1 && n < 34000) begin
      acc(7'h0a, 1'h0, 8'h00);
      n++;
    end
    chk(q, 8'ha0);
    chk({7'h00, O_IRQ}, 8'h00);
    cyc(30);
    chk({7'h00, O_IRQ}, 8'h01);
    rdchk(7'h0c, 8'h90);
    n = 0;
    while (O_SECOND_TICK !== 1'h1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk({7'h00, O_SECOND_TICK}, 8'h01);
    cyc(1);
    chk({7'h00, O_SECOND_TICK}, 8'h00);
    // a stopped divider chain yields no periodic flag
    acc(7'h0a, 1'h1, 8'h63);
    cyc(40);
    rdchk(7'h0c, 8'h00);
    acc(7'h0a, 1'h1, 8'h23);
    cyc(20);
    rdchk(7'h0c, 8'h40);
    final_report();
  end
endmodule // rtc_ctrl_regs_tb
bind rtc_ctrl_regs rtc_ctrl_regs_properties u_rtc_ctrl_regs_properties (.I_CLK, .I_SRST, .I_IDX_WR, .I_DATA_WR,
  .I_DATA_RD, .I_ALARM_MATCH, .I_POWER_GOOD, .I_WDATA, .O_RDATA, .O_UPDATE_HALT, .O_BINARY, .O_HOUR24,
  .O_DST_EN, .O_IRQ);
